// >>> design/gpp_port.v
/*
 * 8-pin general purpose i/o port with alternate-function override and
 * grouped external interrupt requests, reached over ahb-lite.
 * assumes the pad resolves drive/enable/pull, peripherals present their
 * alternate-function controls on the same clock, and the cpu pulses
 * vector_fetch when it fetches an external interrupt vector.
 */
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
// Function
// - eight pins, each steered by the same bit of every register; code gives sensitivity two bits per pin, bits 2i+1:2i
// - input pin: data read returns synchronised pad level
// - data write on input pin changes latch only, pad undisturbed
// - interrupt-input pin raises request on qualifying event independently
// - per group, detect each pin by sensitivity, then or together
// - request latch hidden, cleared when cpu fetches its vector; the code reads it back at status offset 8'h10
// - writing sensitivity discards pending request of that group; code only when an interrupt pin's field changes
// - output pin: latch drives pad, read returns latch
// - latch 0 drives low; 1 drives high or floats in open drain
// - enabled alternate function overrides normal register setup
// - peripheral output forces pin output, drive type from peripheral
// - peripheral input needs input pin; pad level still readable
// - input pin with alternate output reads back alternate output
// - output pin with alternate input feeds latch to peripheral
// - low-power states leave port alone; requests still wake
// - request only in interrupt mode with cpu mask inactive
// - standard pins: 00 float, 01 pull-up, 10 open drain, 11 push-pull
// - interrupt pins: 01 interrupt input, pull-up per group option; code picks it per pin by IRQ_PULLUP
// - true open-drain pins: direction alone, output never drives high
`timescale 1ns/1ns
`default_nettype none
`include "gpp_regs.vh"

module gpp_port #(
  parameter       NPINS      = 8,
  parameter       NGROUPS    = 4,
  // per-pin capability masks
  parameter [7:0] IRQ_PINS   = 8'h0f,
  parameter [7:0] IRQ_PULLUP = 8'h07,
  parameter [7:0] TRUE_OD    = 8'hc0,
  // group index of each pin, two bits per pin
  parameter [15:0] PIN_GROUP = 16'h0000
) (
  input  wire                 clock,
  input  wire                 reset_n,
  // ahb-lite slave
  input  wire                 hsel,
  input  wire [7:0]           haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output reg  [31:0]          hrdata,
  output reg                  hreadyout,
  output reg                  hresp,
  // pads
  input  wire [NPINS-1:0]     pad_in,
  output reg  [NPINS-1:0]     pad_out,
  output reg  [NPINS-1:0]     pad_oe_n,
  output reg  [NPINS-1:0]     pad_pullup,
  // alternate functions
  input  wire [NPINS-1:0]     alt_out_en,
  input  wire [NPINS-1:0]     alt_out,
  input  wire [NPINS-1:0]     alt_open_drain,
  input  wire [NPINS-1:0]     alt_in_en,
  output reg  [NPINS-1:0]     alt_in,
  // cpu side
  input  wire                 cpu_irq_masked,
  input  wire [NGROUPS-1:0]   vector_fetch,
  output reg  [NGROUPS-1:0]   ext_irq_req,
  output reg                  wake_req
);

  // ************************************************************
  // registers and state
  // ************************************************************
  reg  [NPINS-1:0]     port_data_latch;
  reg  [NPINS-1:0]     port_direction;
  reg  [NPINS-1:0]     port_option;
  reg  [2*NPINS-1:0]   ext_irq_sensitivity_control;
  reg  [NPINS-1:0]     prev_level;
  reg  [NGROUPS-1:0]   pending;
  wire [NPINS-1:0]     pin_level;

  // address phase capture
  reg                  dp_write;
  reg                  dp_read;
  reg  [7:0]           dp_addr;

  // ************************************************************
  // pad input synchroniser
  // ************************************************************
  gpp_sync #(
    .WIDTH (NPINS)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (pad_in),
    .sync_out (pin_level)
  );

  // ************************************************************
  // synchroniser fill after reset
  // ************************************************************
  // synchroniser and prev_level wake at 0 while an idle pulled-up pad
  // sits at 1; edges are ignored until both carry real pad levels.
  // a reset value of 1 in the stages would fake falls on grounded pads
  reg  [1:0]           fill_count;
  wire                 sync_primed = (fill_count == `GPP_SYNC_FILL);

  always @(posedge clock) begin
    if (!reset_n) begin
      fill_count <= 2'h0;
    end else if (!sync_primed) begin
      fill_count <= fill_count + 2'h1;
    end
  end

  // ************************************************************
  // ahb-lite address phase
  // ************************************************************
  // hsize is not decoded: only whole-word transfers are expected
  wire access = hsel && hready && htrans[1];

  always @(posedge clock) begin
    if (!reset_n) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= access && hwrite;
      dp_read  <= access && !hwrite;
      dp_addr  <= haddr;
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  wire wr_data = dp_write && (dp_addr == `GPP_OFF_DATA);
  wire wr_dir  = dp_write && (dp_addr == `GPP_OFF_DIR);
  wire wr_opt  = dp_write && (dp_addr == `GPP_OFF_OPT);
  wire wr_sens = dp_write && (dp_addr == `GPP_OFF_SENS);

  always @(posedge clock) begin
    if (!reset_n) begin
      port_data_latch             <= `GPP_RST_DATA;
      port_direction              <= `GPP_RST_DIR;
      port_option                 <= `GPP_RST_OPT;
      ext_irq_sensitivity_control <= `GPP_RST_SENS;
    end else begin
      if (wr_data)
        port_data_latch <= hwdata[NPINS-1:0];
      if (wr_dir)
        port_direction <= hwdata[NPINS-1:0];
      if (wr_opt)
        port_option <= hwdata[NPINS-1:0] & ~TRUE_OD;
      if (wr_sens)
        ext_irq_sensitivity_control <= hwdata[2*NPINS-1:0];
    end
  end

  // ************************************************************
  // read forwarding
  // ************************************************************
  // a read whose address phase meets a write's data phase sees the
  // value being written, so back-to-back transfers read coherently;
  // status is not forwarded, a flush shows one read later
  wire [NPINS-1:0]    fwd_latch = wr_data ? hwdata[NPINS-1:0]
                                          : port_data_latch;
  wire [NPINS-1:0]    fwd_dir   = wr_dir ? hwdata[NPINS-1:0]
                                         : port_direction;
  wire [NPINS-1:0]    fwd_opt   = wr_opt ? (hwdata[NPINS-1:0] & ~TRUE_OD)
                                         : port_option;
  wire [2*NPINS-1:0]  fwd_sens  = wr_sens ? hwdata[2*NPINS-1:0]
                                          : ext_irq_sensitivity_control;

  // ************************************************************
  // per-pin mode, drive and readback
  // ************************************************************
  reg  [NPINS-1:0] next_pad_out;
  reg  [NPINS-1:0] next_pad_oe_n;
  reg  [NPINS-1:0] next_pad_pullup;
  reg  [NPINS-1:0] next_alt_in;
  reg  [NPINS-1:0] read_data;
  wire [NPINS-1:0] irq_mode;
  wire [NPINS-1:0] event_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      wire dir = port_direction[gi];
      wire opt = port_option[gi];
      wire altd = alt_out_en[gi];
      // interrupt input only on capable pins, dir 0 opt 1
      assign irq_mode[gi] = IRQ_PINS[gi] && !dir && opt;
      wire [1:0] sens =
        ext_irq_sensitivity_control[2*gi+1:2*gi];
      reg hit;
      always @* begin
        hit = 1'b0;
        case (sens)
          `GPP_SENS_FALL_LOW: hit = !pin_level[gi];
          `GPP_SENS_RISE:     hit = pin_level[gi] && !prev_level[gi];
          `GPP_SENS_FALL:     hit = !pin_level[gi] && prev_level[gi];
          `GPP_SENS_BOTH:     hit = pin_level[gi] ^ prev_level[gi];
          default:            hit = 1'b0;
        endcase
      end
      assign event_hit[gi] = hit && irq_mode[gi] && sync_primed;

      always @* begin
        if (altd) begin
          // peripheral owns the pin as output
          next_pad_out[gi]    = alt_out[gi];
          next_pad_oe_n[gi]   = (alt_open_drain[gi] || TRUE_OD[gi])
                                && alt_out[gi];
          next_pad_pullup[gi] = 1'b0;
        end else if (dir) begin
          // latch drives; 1 floats in open drain
          next_pad_out[gi]    = port_data_latch[gi];
          next_pad_oe_n[gi]   = (!opt || TRUE_OD[gi])
                                && port_data_latch[gi];
          next_pad_pullup[gi] = 1'b0;
        end else begin
          // input: pad released
          next_pad_out[gi]    = 1'b0;
          next_pad_oe_n[gi]   = 1'b1;
          // floating interrupt pins never pull
          next_pad_pullup[gi] = opt && !TRUE_OD[gi] &&
                                (!IRQ_PINS[gi] || IRQ_PULLUP[gi]);
        end
        // quiet while the peripheral does not listen
        if (alt_in_en[gi])
          next_alt_in[gi] = dir ? port_data_latch[gi] : pin_level[gi];
        else
          next_alt_in[gi] = 1'b0;
        // register side forwarded
        if (fwd_dir[gi])
          read_data[gi] = fwd_latch[gi];
        else if (altd)
          read_data[gi] = alt_out[gi];
        else
          read_data[gi] = pin_level[gi];
      end
    end
  endgenerate

  // ************************************************************
  // grouped request latches
  // ************************************************************
  reg [NGROUPS-1:0] group_hit;
  reg [NGROUPS-1:0] sens_touch;
  integer k;
  always @* begin
    group_hit  = {NGROUPS{1'b0}};
    sens_touch = {NGROUPS{1'b0}};
    for (k = 0; k < NPINS; k = k + 1) begin
      // or of detected pins per group
      if (event_hit[k])
        group_hit[PIN_GROUP[2*k +: 2]] = 1'b1;
      if (wr_sens && IRQ_PINS[k] &&
          (hwdata[2*k +: 2] != ext_irq_sensitivity_control[2*k +: 2]))
        sens_touch[PIN_GROUP[2*k +: 2]] = 1'b1;
    end
  end

  // a new event beats a vector fetch in the same cycle, so none is lost;
  // a sensitivity change discards regardless, being a deliberate flush
  wire [NGROUPS-1:0] next_pending =
    ((pending & ~vector_fetch) | group_hit) & ~sens_touch;

  always @(posedge clock) begin
    if (!reset_n) begin
      prev_level  <= {NPINS{1'b0}};
      pending     <= {NGROUPS{1'b0}};
      ext_irq_req <= {NGROUPS{1'b0}};
      wake_req    <= 1'b0;
    end else begin
      prev_level  <= pin_level;
      pending     <= next_pending;
      // mask gates delivery only; request stays latched
      ext_irq_req <= cpu_irq_masked ? {NGROUPS{1'b0}} : next_pending;
      // wake from wait and halt, port otherwise unaffected
      wake_req    <= |next_pending;
    end
  end

  // ************************************************************
  // pad and peripheral outputs
  // ************************************************************
  // registered so pads never see decode glitches
  always @(posedge clock) begin
    if (!reset_n) begin
      pad_out    <= {NPINS{1'b0}};
      pad_oe_n   <= {NPINS{1'b1}};
      pad_pullup <= {NPINS{1'b0}};
      alt_in     <= {NPINS{1'b0}};
    end else begin
      pad_out    <= next_pad_out;
      pad_oe_n   <= next_pad_oe_n;
      pad_pullup <= next_pad_pullup;
      alt_in     <= next_alt_in;
    end
  end

  // ************************************************************
  // ahb-lite data phase: zero wait, always okay
  // ************************************************************
  // read data stands for the data phase only, zero otherwise
  reg [31:0] next_hrdata;
  always @* begin
    next_hrdata = 32'h0000_0000;
    if (access && !hwrite) begin
      case (haddr)
        `GPP_OFF_DATA:   next_hrdata[NPINS-1:0] = read_data;
        `GPP_OFF_DIR:    next_hrdata[NPINS-1:0] = fwd_dir;
        `GPP_OFF_OPT:    next_hrdata[NPINS-1:0] = fwd_opt;
        `GPP_OFF_SENS:   next_hrdata[2*NPINS-1:0] = fwd_sens;
        `GPP_OFF_STATUS: next_hrdata[NGROUPS-1:0] = pending;
        default:         next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> design/gpp_regs.vh
/*
 * register offsets, reset values and mode encodings of the general
 * purpose i/o port. assumes a 32-bit ahb-lite register bus, one word
 * per register.
 */
`ifndef GPP_REGS_VH
`define GPP_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define GPP_OFF_DATA      8'h00
`define GPP_OFF_DIR       8'h04
`define GPP_OFF_OPT       8'h08
`define GPP_OFF_SENS      8'h0c
`define GPP_OFF_STATUS    8'h10

// ************************************************************
// reset values
// ************************************************************
`define GPP_RST_DATA      8'h00
`define GPP_RST_DIR       8'h00
`define GPP_RST_OPT       8'h00
`define GPP_RST_SENS      16'h0000

// ************************************************************
// sensitivity encodings, two bits per pin
// ************************************************************
`define GPP_SENS_FALL_LOW 2'h0
`define GPP_SENS_RISE     2'h1
`define GPP_SENS_FALL     2'h2
`define GPP_SENS_BOTH     2'h3

// ************************************************************
// timing counts
// ************************************************************
// edges after reset until synchroniser and prev_level hold pad levels
`define GPP_SYNC_FILL     2'h3

// ************************************************************
// ahb-lite constants
// ************************************************************
`define GPP_HTRANS_NONSEQ 2'h2
`define GPP_HTRANS_SEQ    2'h3
`define GPP_HSIZE_WORD    3'h2

`endif

// >>> design/gpp_sync.v
/*
 * two-stage level synchroniser, one stage pair per bit.
 * assumes inputs asynchronous to clock.
 */
`timescale 1ns/1ns
`default_nettype none

module gpp_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // ************************************************************
  // synchroniser stages
  // ************************************************************
  always @(posedge clock) begin
    if (!reset_n) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// >>> sim/gpp_port_asserts.sv
/* checker for the port block: bus answers, pad drive, request gating.
   assumes it is bound to gpp_port with its default pin masks. */
`timescale 1ns/1ns
`default_nettype none
module gpp_port_asserts (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  pad_out,
  input wire logic [7:0]  pad_oe_n,
  input wire logic [7:0]  pad_pullup,
  input wire logic [7:0]  alt_out_en,
  input wire logic [7:0]  alt_out,
  input wire logic [7:0]  alt_open_drain,
  input wire logic        cpu_irq_masked,
  input wire logic [3:0]  vector_fetch,
  input wire logic [3:0]  ext_irq_req,
  input wire logic        wake_req
);
  // ************************************************************
  // helper terms
  // ************************************************************
  // true open-drain pins are left out: their drive type is fixed
  wire logic [7:0] pp = alt_out_en & ~alt_open_drain & 8'h3f;
  wire logic [7:0] od = alt_out_en & alt_open_drain & 8'h3f;
  wire logic       rd = hsel && hready && htrans[1] && !hwrite;
  wire logic       sw = hsel && hready && htrans[1] && hwrite;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_read_idle: assert property (
    !$past(rd && haddr < 8'h14) |-> hrdata == 32'h0)
    else $error("read data outside a mapped read");
  chk_alt_push: assert property (
    pp != 8'h0 |=>
      ((pad_oe_n | (pad_out ^ $past(alt_out))) & $past(pp)) == 8'h0)
    else $error("push-pull alternate output not driven");
  chk_alt_odrain: assert property (
    od != 8'h0 |=> (((pad_oe_n ^ $past(alt_out)) | (~pad_oe_n & pad_out))
      & $past(od)) == 8'h0)
    else $error("open-drain alternate output wrong");
  chk_tod_drive: assert property (
    (((~pad_oe_n & pad_out) | pad_pullup) & 8'hc0) == 8'h0)
    else $error("true open-drain pin driven high or pulled");
  chk_req_wake: assert property (ext_irq_req != 4'h0 |-> wake_req)
    else $error("request without wake");
  chk_mask_gate: assert property (
    cpu_irq_masked |=> ext_irq_req == 4'h0)
    else $error("request while cpu mask active");
  chk_clear_cause: assert property (
    $fell(wake_req) |-> $past(|vector_fetch)
      || ($past(sw, 2) && $past(haddr, 2) == 8'h0c))
    else $error("pending request dropped without cause");

  cover property ($rose(ext_irq_req[0]));
  cover property (cpu_irq_masked && wake_req);
  cover property (rd && haddr == 8'h10);
endmodule

bind gpp_port gpp_port_asserts u_chk (
  .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pad_out(pad_out),
  .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .alt_out_en(alt_out_en),
  .alt_out(alt_out), .alt_open_drain(alt_open_drain),
  .cpu_irq_masked(cpu_irq_masked), .vector_fetch(vector_fetch),
  .ext_irq_req(ext_irq_req), .wake_req(wake_req));
`default_nettype wire

// >>> sim/gpp_pad_env.sv
/* pad-side model: resolves device drive, outside drive and pull-up.
   assumes outside drivers never fight the device on purpose. */
`timescale 1ns/1ns
`default_nettype none
module gpp_pad_env (
  input wire logic       clock,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic     [7:0] pad_in
);
  logic [7:0] flt = 8'h00;
  // a released unpulled pin wanders, so a stale level never passes
  always @(posedge clock) begin
    flt <= ~flt;
  end
  always_comb begin
    pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
           | (pad_oe_n & ~ext_en & (pad_pullup | flt));
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
/* self-checking bench: registers, pad modes, alternate functions and
   requests against a bench model. assumes default port parameters. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic             clock = 1'b0;
  logic             reset_n = 1'b0;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic             cpu_irq_masked = 1'b0;
  logic [1:0]       htrans = 2'h0;
  logic [2:0]       hsize = 3'h2;
  logic [7:0]       haddr = 8'h00;
  logic [31:0]      hwdata = 32'h0;
  logic [3:0]       fetch = 4'h0;
  logic [7:0]       ae = 8'h00, ao = 8'h00, aod = 8'h00, aie = 8'h00;
  logic [7:0]       ee = 8'h00, ev = 8'h00;
  logic [7:0]       lat, dir, opt, oe, dv, xd, xp, xa;
  logic [31:0]      q, t;
  logic             exp;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, wake_req;
  wire logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup, alt_in;
  wire logic [3:0]  ext_irq_req;
  integer           seed = 62, failures = 0, tests_run = 0, cyc = 0, i, m;

  always #4 clock = ~clock;

  gpp_port i_dut (.clock(clock), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .alt_out_en(ae), .alt_out(ao),
    .alt_open_drain(aod), .alt_in_en(aie), .alt_in(alt_in),
    .cpu_irq_masked(cpu_irq_masked), .vector_fetch(fetch),
    .ext_irq_req(ext_irq_req), .wake_req(wake_req));
  gpp_pad_env i_env (.clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .ext_en(ee), .ext_val(ev), .pad_in(pad_in));

  // ************************************************************
  // bus, compare and closing tasks
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic fetch_pulse;
    @(posedge clock);
    fetch <= 4'h1;
    @(posedge clock);
    fetch <= 4'h0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      report_and_stop();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b1, 8'h14, 32'hffffffff, q);
    for (i = 1; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, q);
      chk("reset read", 32'h0, q);
    end
    for (i = 0; i < 16; i++) begin
      t = $random(seed);
      lat = t[7:0];
      dir = t[15:8];
      opt = t[23:16];
      t = $random(seed);
      @(posedge clock);
      // alternate outputs kept off interrupt-capable pins
      ae <= t[7:0] & 8'h30;
      ee <= ~dir & ~(t[7:0] & 8'h30);
      ao <= t[15:8];
      aod <= t[23:16];
      aie <= t[31:24] & ~(t[7:0] & 8'h30);
      ev <= 8'($random(seed));
      bus(1'b1, 8'h00, {24'h0, lat}, q);
      bus(1'b1, 8'h04, {24'h0, dir}, q);
      bus(1'b1, 8'h08, {24'h0, opt}, q);
      repeat (5) @(posedge clock);
      oe = (ae & aod & ao) | (~ae & (~dir | (~(opt & 8'h3f) & lat)));
      dv = (ae & ao) | (~ae & lat);
      xd = (dir & lat) | (~dir & ae & ao) | (~dir & ~ae & ev);
      xp = ~dir & opt & 8'h37 & ~ae;
      xa = ((dir & lat) | (~dir & ev)) & aie;
      bus(1'b0, 8'h00, 32'h0, q);
      chk("data", xd, q);
      bus(1'b0, 8'h04, 32'h0, q);
      chk("direction", dir, q);
      bus(1'b0, 8'h08, 32'h0, q);
      chk("option", opt & 8'h3f, q);
      chk("pad enable", oe, pad_oe_n);
      chk("pad value", dv & ~oe, pad_out & ~pad_oe_n);
      chk("pull-up", xp, pad_pullup);
      chk("alt input", xa, alt_in);
    end
    @(posedge clock);
    ae <= 8'h00;
    ee <= 8'hff;
    ev <= 8'hff;
    bus(1'b1, 8'h04, 32'h0, q);
    bus(1'b1, 8'h08, 32'h1, q);
    for (m = 0; m < 4; m++) begin
      bus(1'b1, 8'h0c, 32'(m), q);
      fetch_pulse();
      repeat (5) @(posedge clock);
      ev <= 8'hfe;
      repeat (6) @(posedge clock);
      exp = (m != 1);
      bus(1'b0, 8'h10, 32'h0, q);
      chk("pending after fall", {31'h0, exp}, q);
      chk("request", {3'h0, exp}, ext_irq_req);
      fetch_pulse();
      ev <= 8'hff;
      repeat (6) @(posedge clock);
      exp = (m != 2);
      bus(1'b0, 8'h10, 32'h0, q);
      chk("pending after rise", {31'h0, exp}, q);
      cpu_irq_masked <= 1'b1;
      repeat (3) @(posedge clock);
      chk("masked request", 32'h0, ext_irq_req);
      chk("wake", {31'h0, exp}, wake_req);
      cpu_irq_masked <= 1'b0;
      bus(1'b1, 8'h0c, 32'((m + 1) % 4), q);
      bus(1'b0, 8'h10, 32'h0, q);
      chk("pending dropped", 32'h0, q);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
